// ===== design/rmc_ctrl.v
// rmc_ctrl.v: pin-level control of a synthesised radio module with apb registers
// assumes pins arrive asynchronously; synth lock and carrier come from analog logic
`include "rmc_defines.vh"

module rmc_ctrl #(
  parameter [`RMC_DEB_W-1:0] DEB_CYC = `RMC_DEB_CYC
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // host pins
  input  wire        reset_pin_n,
  input  wire        transmit_enable_n,
  input  wire        receive_enable_n,
  input  wire        channel_step,
  input  wire        step_direction,
  input  wire        source_select_a,
  input  wire        source_select_b,
  input  wire [4:0]  channel_switch,
  // serial channel load from the serial port decoder, same clock
  input  wire        serial_ch_load,
  input  wire [4:0]  serial_ch_value,
  // analog side status, asynchronous
  input  wire        synth_locked,
  input  wire        carrier_above,
  // outputs
  output reg         cpu_reset_n,
  output reg         tx_on,
  output reg         rx_on,
  output reg  [2:0]  mod_source,
  output reg  [4:0]  channel,
  output reg         lock_ready_n,
  output reg         radio_active,
  output reg         carrier_detect,
  output wire        irq
);

  // synchronisers for level pins: stage 1 read only by stage 2
  localparam NSYNC = 8;
  wire [NSYNC-1:0] raw_in = {carrier_above, synth_locked, source_select_b,
                             source_select_a, step_direction, receive_enable_n,
                             transmit_enable_n, reset_pin_n};
  wire [NSYNC-1:0] sync_w;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // each bit keeps its own flops, so no vector is driven from several processes
      reg s1_r;
      reg s2_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
        end else begin
          s1_r <= raw_in[gi];
          s2_r <= s1_r;
        end
      end
      assign sync_w[gi] = s2_r;
    end
  endgenerate

  wire rst_pin_s = sync_w[0];
  wire txen_n_s  = sync_w[1];
  wire rxen_n_s  = sync_w[2];
  wire dir_s     = sync_w[3];
  wire sel_a_s   = sync_w[4];
  wire sel_b_s   = sync_w[5];
  wire locked_s  = sync_w[6];
  wire carrier_s = sync_w[7];

  // channel switches pass the same two flops before use
  reg [4:0] sw1_r;
  reg [4:0] sw2_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw1_r <= 5'h00;
      sw2_r <= 5'h00;
    end else begin
      sw1_r <= channel_switch;
      sw2_r <= sw1_r;
    end
  end

  // debounced step input
  wire step_fall;
  rmc_debounce #(
    .DEB_CYC (DEB_CYC)
  ) u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_raw (channel_step),
    .level_r (),
    .fall    (step_fall)
  );

  // apb registers: ctrl hold, ro status, ro channel, w1c irq status, irq mask
  // status and channel are read only; writes to them are dropped like unmapped ones
  reg                 hold_r;
  reg [`RMC_RELOAD_W-1:0] reload_cnt_r;
  reg [`RMC_EV_W-1:0] irq_st_r;
  reg [`RMC_EV_W-1:0] irq_msk_r;
  reg                 reload_r;
  reg                 locked_d_r;
  reg                 carrier_d_r;

  wire wr_en = psel & penable & pwrite;
  assign pready  = 1'b1;   // zero wait states: every access ends in its first access cycle
  assign pslverr = 1'b0;   // unmapped offsets read zero, writes dropped

  // mode decode from the enables
  reg tx_nxt;
  reg rx_nxt;
  always @* begin
    tx_nxt = ~txen_n_s;
    rx_nxt = txen_n_s & ~rxen_n_s;
  end

  // source select; which line picks analogue versus direct is unsure, a=high gives analogue
  reg [2:0] src_nxt;
  always @* begin
    case ({sel_b_s, sel_a_s})
      2'b11:   src_nxt = `RMC_SRC_DIGITAL;
      2'b01:   src_nxt = `RMC_SRC_ANALOG;
      2'b10:   src_nxt = `RMC_SRC_DIRECT;
      default: src_nxt = `RMC_SRC_NONE;      // both low is undefined: drive nothing
    endcase
  end

  // channel next value: serial load wins over a step in the same cycle
  reg [4:0] ch_nxt;
  reg       limit_hit;
  always @* begin
    ch_nxt    = channel;
    limit_hit = 1'b0;
    if (reload_r) begin
      ch_nxt = sw2_r;
    end else if (serial_ch_load) begin
      ch_nxt = serial_ch_value;
    end else if (step_fall) begin
      if (dir_s) begin
        if (channel == `RMC_CH_MAX) limit_hit = 1'b1;
        else ch_nxt = channel + 5'h01;
      end else begin
        if (channel == `RMC_CH_MIN) limit_hit = 1'b1;
        else ch_nxt = channel - 5'h01;
      end
    end
  end

  // events that raise sticky interrupt bits
  wire [`RMC_EV_W-1:0] ev;
  assign ev[`RMC_EV_STEP]    = step_fall & ~limit_hit & ~reload_r & ~serial_ch_load;
  assign ev[`RMC_EV_LOCK]    = locked_s & ~locked_d_r;
  assign ev[`RMC_EV_CARRIER] = carrier_s & ~carrier_d_r;
  assign ev[`RMC_EV_LIMIT]   = limit_hit;

  assign irq = |(irq_st_r & irq_msk_r);

  // main state: registers and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r         <= 1'b0;
      irq_st_r       <= {`RMC_EV_W{1'b0}};
      irq_msk_r      <= {`RMC_EV_W{1'b0}};
      reload_r       <= 1'b1;
      reload_cnt_r   <= `RMC_RELOAD_CYC;
      // match the synchroniser reset level, so no false rise follows reset
      locked_d_r     <= 1'b1;
      carrier_d_r    <= 1'b1;
      cpu_reset_n    <= 1'b0;
      tx_on          <= 1'b0;
      rx_on          <= 1'b0;
      mod_source     <= `RMC_SRC_NONE;
      channel        <= `RMC_CH_MIN;
      lock_ready_n   <= 1'b1;
      radio_active   <= 1'b0;
      carrier_detect <= 1'b0;
    end else begin
      // reload waits for the switch synchroniser to settle; pin reset re-arms it
      reload_r       <= ~rst_pin_s | (reload_cnt_r != {`RMC_RELOAD_W{1'b0}});
      if (!rst_pin_s)
        reload_cnt_r <= `RMC_RELOAD_CYC;
      else if (reload_cnt_r != {`RMC_RELOAD_W{1'b0}})
        reload_cnt_r <= reload_cnt_r - 1'b1;
      locked_d_r     <= locked_s;
      carrier_d_r    <= carrier_s;
      cpu_reset_n    <= rst_pin_s & ~hold_r;
      tx_on          <= tx_nxt;
      rx_on          <= rx_nxt;
      radio_active   <= tx_nxt | rx_nxt;
      mod_source     <= src_nxt;
      channel        <= ch_nxt;
      lock_ready_n   <= ~(locked_s & (tx_nxt | rx_nxt));
      carrier_detect <= carrier_s & rx_nxt;
      if (wr_en && paddr == `RMC_OFS_CTRL)
        hold_r <= pwdata[`RMC_CTRL_HOLD];
      if (wr_en && paddr == `RMC_OFS_IRQ_MSK)
        irq_msk_r <= pwdata[`RMC_EV_W-1:0];
      // a new event beats a write-one-to-clear in the same cycle
      if (wr_en && paddr == `RMC_OFS_IRQ_ST)
        irq_st_r <= (irq_st_r & ~pwdata[`RMC_EV_W-1:0]) | ev;
      else
        irq_st_r <= irq_st_r | ev;
    end
  end

  // read mux, registered in the setup cycle so data is ready in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `RMC_OFS_CTRL:    prdata <= {31'h00000000, hold_r};
        `RMC_OFS_STATUS:  prdata <= {28'h0000000, carrier_detect, ~lock_ready_n,
                                     rx_on, tx_on};
        `RMC_OFS_CHAN:    prdata <= {27'h0000000, channel};
        `RMC_OFS_IRQ_ST:  prdata <= {28'h0000000, irq_st_r};
        `RMC_OFS_IRQ_MSK: prdata <= {28'h0000000, irq_msk_r};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // rmc_ctrl

// ===== design/rmc_defines.vh
// rmc_defines.vh: constants of the radio module control block
// assumes inclusion by bare name from every design file that needs it
`ifndef RMC_DEFINES_VH
`define RMC_DEFINES_VH

// register byte offsets on apb
`define RMC_OFS_CTRL    12'h000
`define RMC_OFS_STATUS  12'h004
`define RMC_OFS_CHAN    12'h008
`define RMC_OFS_IRQ_ST  12'h00C
`define RMC_OFS_IRQ_MSK 12'h010

// ctrl fields: bit 0 holds the processor in reset
`define RMC_CTRL_HOLD   0

// status fields
`define RMC_ST_TX       0
`define RMC_ST_RX       1
`define RMC_ST_LOCK     2
`define RMC_ST_CARRIER  3

// interrupt events
`define RMC_EV_STEP     0
`define RMC_EV_LOCK     1
`define RMC_EV_CARRIER  2
`define RMC_EV_LIMIT    3
`define RMC_EV_W        4

// channel limits and width
`define RMC_CH_W        5
`define RMC_CH_MIN      5'h00
`define RMC_CH_MAX      5'h1F

// debounce: 10 ms at 50 MHz, sized to the filter counter width
`define RMC_DEB_CYC     20'h7A120
`define RMC_DEB_W       20

// switch reload stretch: covers the two-flop switch path after any reset
`define RMC_RELOAD_W    2
`define RMC_RELOAD_CYC  2'h3

// modulation source codes
`define RMC_SRC_W       3
`define RMC_SRC_DIGITAL 3'h1
`define RMC_SRC_ANALOG  3'h2
`define RMC_SRC_DIRECT  3'h4
`define RMC_SRC_NONE    3'h0

`endif

// ===== design/rmc_debounce.v
// rmc_debounce.v: two-flop synchroniser plus stability filter for a switch input
// assumes a bouncing mechanical contact, idle high by pull-up
`include "rmc_defines.vh"

module rmc_debounce #(
  parameter [`RMC_DEB_W-1:0] DEB_CYC = `RMC_DEB_CYC
) (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // raw pin and filtered level
  input  wire pin_raw,
  output reg  level_r,
  output wire fall
);

  reg                 sync1_r;
  reg                 sync2_r;
  reg [`RMC_DEB_W-1:0] cnt_r;
  reg                 fall_r;

  assign fall = fall_r;

  // first flop feeds only the second; the filter reads the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      cnt_r   <= {`RMC_DEB_W{1'b0}};
      level_r <= 1'b1;
      fall_r  <= 1'b0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      fall_r  <= 1'b0;
      // level only moves after the input has been steady for DEB_CYC cycles
      if (sync2_r == level_r) begin
        cnt_r <= {`RMC_DEB_W{1'b0}};
      end else if (cnt_r >= DEB_CYC - 1'b1) begin
        cnt_r   <= {`RMC_DEB_W{1'b0}};
        level_r <= sync2_r;
        fall_r  <= level_r & ~sync2_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule // rmc_debounce

// ===== test/rmc_sw_model.sv
// rmc_sw_model.sv: step switch in front of the control pins, with contact bounce
// assumes the bench raises press for one closure; pin idles high by pull-up
module rmc_sw_model (
  // clock
  input  wire  pclk,
  // closure command and switch pin
  input  wire  press,
  output logic channel_step
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] bounce_r;
  logic       press_r;
  // bounce is kept shorter than the filter span, so only one step may result
  always @(posedge pclk) begin
    press_r <= press;
    bounce_r <= (press && !press_r) ? 2'h3 : (bounce_r != 2'h0 ? bounce_r - 2'h1 : 2'h0);
    channel_step <= press ? (bounce_r != 2'h0 && bounce_r[0]) : 1'b1;
  end
endmodule // rmc_sw_model

// ===== test/rmc_ctrl_monitor.sv
// rmc_ctrl_monitor.sv: pin-level assertions for the radio control block
// assumes one clock domain; pins show three edges after they settle
module rmc_ctrl_monitor #(
  parameter [19:0] DEB_CYC = 20'h7A120
) (
  // clock and reset
  input wire       pclk,
  input wire       presetn,
  // pins
  input wire       reset_pin_n,
  input wire       transmit_enable_n,
  input wire       receive_enable_n,
  input wire       channel_step,
  input wire       source_select_a,
  input wire       source_select_b,
  input wire       serial_ch_load,
  input wire       synth_locked,
  input wire       carrier_above,
  // outputs
  input wire       cpu_reset_n,
  input wire       tx_on,
  input wire       rx_on,
  input wire [2:0] mod_source,
  input wire [4:0] channel,
  input wire       lock_ready_n,
  input wire       radio_active,
  input wire       carrier_detect
);
  // checks start one edge after reset release: outputs still show reset values then
  logic rst_done_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_done_r <= 1'b0;
    end else begin
      rst_done_r <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!rst_done_r);
  // four samples cover the two sync flops and the output register
  a_cpu_hold: assert property (!reset_pin_n [*4] |-> !cpu_reset_n)
    else $error("processor not held in reset");
  a_tx_wins: assert property (!transmit_enable_n [*4] |-> tx_on && !rx_on)
    else $error("transmit decode wrong");
  a_rx_mode: assert property ((transmit_enable_n && !receive_enable_n) [*4] |-> rx_on && !tx_on)
    else $error("receive decode wrong");
  a_power_down: assert property ((transmit_enable_n && receive_enable_n) [*4] |-> !radio_active && !tx_on)
    else $error("activity high in power down");
  a_no_carrier: assert property (!carrier_above [*4] |-> !carrier_detect)
    else $error("carrier detect without carrier");
  a_src_digital: assert property ((source_select_a && source_select_b) [*4] |-> mod_source == 3'h1)
    else $error("digital source not selected");
  a_src_onehot: assert property ($onehot0(mod_source))
    else $error("more than one source routed");
  a_unlocked: assert property (!synth_locked [*4] |-> lock_ready_n)
    else $error("lock indicator low while unlocked");
  a_chan_quiet: assert property ((channel_step && reset_pin_n && !serial_ch_load) [*8] |=> $stable(channel))
    else $error("channel moved with no step");
endmodule // rmc_ctrl_monitor

bind rmc_ctrl rmc_ctrl_monitor #(.DEB_CYC(DEB_CYC)) u_rmc_ctrl_monitor (.pclk, .presetn,
  .reset_pin_n, .transmit_enable_n, .receive_enable_n, .channel_step, .source_select_a,
  .source_select_b, .serial_ch_load, .synth_locked, .carrier_above, .cpu_reset_n, .tx_on,
  .rx_on, .mod_source, .channel, .lock_ready_n, .radio_active, .carrier_detect);

// ===== test/rmc_ctrl_tb.sv
// rmc_ctrl_tb.sv: self-checking bench for the radio control block
// assumes a short debounce span of four cycles and zero-wait apb
module rmc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, press, irq;
  logic reset_pin_n, transmit_enable_n, receive_enable_n, channel_step, step_direction;
  logic source_select_a, source_select_b, serial_ch_load, synth_locked, carrier_above;
  logic cpu_reset_n, tx_on, rx_on, lock_ready_n, radio_active, carrier_detect;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  channel_switch, serial_ch_value, channel;
  logic [2:0]  mod_source;
  int fails, checks_done;
  // pins {txn,rxn,sel_a,sel_b,carrier,locked} beside {tx,rx,active,source,cd,lock_n}
  logic [13:0] rows [5] = '{14'h0CA5, 14'h2D64, 14'h17B0, 14'h3301, 14'h2B6A};

  rmc_ctrl #(.DEB_CYC(20'h00004)) u_rmc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .transmit_enable_n,
    .receive_enable_n, .channel_step, .step_direction, .source_select_a, .source_select_b,
    .channel_switch, .serial_ch_load, .serial_ch_value, .synth_locked, .carrier_above,
    .cpu_reset_n, .tx_on, .rx_on, .mod_source, .channel, .lock_ready_n, .radio_active,
    .carrier_detect, .irq);
  rmc_sw_model u_rmc_sw_model (.pclk, .press, .channel_step);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; called just after a rising edge, returns one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one switch closure; waits cover bounce, sync, filter and release
  task automatic step(input logic up);
    step_direction <= up;
    press <= 1'b1;
    repeat (16) @(posedge pclk);
    press <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #200000;
    fails++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, press, serial_ch_load, step_direction} = '0;
    {transmit_enable_n, receive_enable_n, source_select_a, source_select_b} = '1;
    {synth_locked, carrier_above, paddr, pwdata, serial_ch_value} = '0;
    reset_pin_n = 1'b1;
    channel_switch = 5'h1E;
    repeat (6) @(posedge pclk);
    chk("cpu_reset_n", 0, cpu_reset_n);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      {transmit_enable_n, receive_enable_n, source_select_a, source_select_b,
       carrier_above, synth_locked} <= rows[i][13:8];
      repeat (5) @(posedge pclk);
      chk("pins", rows[i][7:0], {tx_on, rx_on, radio_active, mod_source, carrier_detect,
          lock_ready_n});
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("status mode", 2'h2, rd[1:0]);
    chk("channel", 5'h1E, channel);
    $display("test pins done");
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("cpu_reset_n", 0, cpu_reset_n);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("channel", 5'h1E, channel);
    apb(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge pclk);
    chk("cpu_reset_n", 0, cpu_reset_n);
    apb(1'b1, 12'h000, 32'h0);
    $display("test reset done");
    step(1'b1);
    chk("channel", 5'h1F, channel);
    chk("irq", 0, irq);
    step(1'b1);
    chk("channel", 5'h1F, channel);
    apb(1'b1, 12'h010, 32'h8);
    chk("irq", 1, irq);
    apb(1'b0, 12'h00C, 32'h0);
    chk("irq status", 4'hF, rd[3:0]);
    apb(1'b1, 12'h00C, 32'hF);
    chk("irq", 0, irq);
    step(1'b0);
    chk("channel", 5'h1E, channel);
    serial_ch_load <= 1'b1;
    @(posedge pclk);
    serial_ch_load <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("channel", 5'h00, channel);
    step(1'b0);
    chk("channel", 5'h00, channel);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped read", 0, rd);
    chk("pslverr", 0, pslverr);
    $display("test steps done");
    // mid-run reset: outputs drop at once, channel reloads from the switches
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", 4'h1, {cpu_reset_n, radio_active, irq, lock_ready_n});
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("channel", 5'h1E, channel);
    chk("active", 1, radio_active);
    apb(1'b0, 12'h00C, 32'h0);
    chk("irq status", 0, rd);
    $display("test mid reset done");
    results();
  end
endmodule // rmc_ctrl_tb
